// ===== logic/adcrq_fmt.sv
// Result read alignment: routes the stored result bits onto a 16-bit word
`timescale 1ns/1ps
module adcrq_fmt (
  input wire logic [adcrq_pkg::RES_W-1:0] raw,
  input wire logic [1:0] sel,
  output logic [15:0] word
);
  import adcrq_pkg::*;

  always_comb begin
    unique case (sel)
      FMT_SIGNED: word = {~raw[RES_W-1], raw[RES_W-2:0], 6'h00};
      FMT_LEFT: word = {raw, 6'h00};
      default: word = {6'h00, raw};
    endcase
  end
endmodule

// ===== logic/adcrq_top.sv
// Result table, command table and queue sequencer with Avalon-MM slave
`timescale 1ns/1ps

// What this block does
// - Result memory holds 64 entries of 10 bits, seen as 16-bit words.
// - A finished conversion stores its result at the command word's index.
// - Unimplemented result bits read zero; writing them changes nothing.
// - Right-aligned read puts result in low bits, zeros above.
// - Signed read left-aligns, inverts the top bit, zeros in six low bits.
// - Unsigned left-aligned read puts result in top bits, zeros below.
// - Address window alone picks the read format; the three result windows share entries.
// - Software writes are always right-aligned, whatever the window.
// - Software may read and write result entries as scratch storage.
// - Queue status reads 0 idle, 8 first active, 4 first paused.
// - Last-done pointers update only when a conversion writes its result.
// - After a pause word the pointer holds until trigger, else advances.
// - Gated single scan restarts the first queue at word zero on reopen.
// - Gate closing lets the running conversion finish, then first queue idles.
// - Gated single scan completion sets first complete flag, clears single-scan enable.
// - Gated continuous sets complete flag and restarts; second completion sets overrun.
// - Channel 63, second queue start, or last entry ends a queue.
// - Pause word stops the queue, sets pause flag, resumes on next trigger.
// - First queue trigger aborts second queue conversion and starts first queue.
module adcrq_top #(
  parameter int DEPTH = adcrq_pkg::ENTRIES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [adcrq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [adcrq_pkg::DATA_W-1:0] writedata,
  input wire logic [adcrq_pkg::BE_W-1:0] byteenable,
  output logic [adcrq_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic extTrig1,
  input wire logic extGate,
  input wire logic extTrig2,
  output logic convStart,
  output logic [adcrq_pkg::IDX_W-1:0] convChannel,
  output logic [1:0] convSample,
  output logic convAbort,
  input wire logic convDone,
  input wire logic [adcrq_pkg::RES_W-1:0] convResult
);
  import adcrq_pkg::*;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic [MODE_W-1:0] mode1;
    logic sse1;
    logic [MODE_W-1:0] mode2;
    logic sse2;
    logic [BQ2_W-1:0] bq2;
    logic cf1;
    logic pf1;
    logic first_queue_trigger_overrun_flag;
    logic cf2;
    logic pf2;
    logic [IDX_W-1:0] command_word_pointer;
    logic [IDX_W-1:0] done1;
    logic [IDX_W-1:0] done2;
    adcrq_seq_t st;
    logic act2;
    logic q2Pend;
    logic gateStop;
    logic [1:0] trig1S;
    logic [1:0] gateS;
    logic [1:0] trig2S;
    logic trig1Prev;
    logic trig2Prev;
    logic start;
    logic abort;
    logic [IDX_W-1:0] chan;
    logic [1:0] smp;
  } adcrq_state_t;

  adcrq_state_t q;
  adcrq_state_t d;

  logic [RES_W-1:0] resRam [DEPTH];
  logic [RES_W-1:0] cmdRam [DEPTH];

  logic [2:0] win;
  logic [IDX_W-1:0] idx;
  logic [1:0] fmtSel;
  logic [15:0] fmtWord;
  logic swWr;
  logic hwWr;
  logic resWr;
  logic cmdWr;
  logic [RES_W-1:0] resWData;
  logic [RES_W-1:0] cmdWData;
  logic [RES_W-1:0] cmdWord;
  logic [DATA_W-1:0] cmdMerged;
  logic [DATA_W-1:0] resMerged;
  logic [DATA_W-1:0] ctrlRead;
  logic [DATA_W-1:0] statRead;
  logic [DATA_W-1:0] ptrRead;
  logic [DATA_W-1:0] ctrlW;
  logic [DATA_W-1:0] clrMask;
  logic swTrig1;
  logic swTrig2;
  logic rise1;
  logic rise2;
  logic gateOpen;
  logic gated1;
  logic q1Trig;
  logic q1Go;
  logic q2Trig;
  logic [1:0] qs1;
  logic [1:0] qs2;

  function automatic logic [DATA_W-1:0] mergeBe(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] nw,
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic isSingle(input logic [MODE_W-1:0] m);
    return (m == MODE_SW_SINGLE) || (m == MODE_EDGE_SINGLE) || (m == MODE_GATE_SINGLE);
  endfunction

  function automatic logic isGated(input logic [MODE_W-1:0] m);
    return (m == MODE_GATE_SINGLE) || (m == MODE_GATE_CONT);
  endfunction

  // Last word of the running queue
  function automatic logic lastOf(
    input logic [IDX_W-1:0] i,
    input logic second,
    input logic [BQ2_W-1:0] bq2
  );
    return (i == CHAN_END) || (!second && (({1'b0, i} + 7'h01) == bq2));
  endfunction

  // Queue completion: flags, single-scan clear, gated continuous restart
  function automatic adcrq_state_t finishQ(input adcrq_state_t s, input logic gOpen);
    adcrq_state_t r;
    r = s;
    r.st = SEQ_IDLE;
    if (s.act2) begin
      r.cf2 = 1'b1;
      if (isSingle(s.mode2)) begin
        r.sse2 = 1'b0;
      end
    end else begin
      if (s.mode1 == MODE_GATE_CONT) begin
        if (s.cf1) begin
          r.first_queue_trigger_overrun_flag = 1'b1;
        end
        if (gOpen) begin
          r.command_word_pointer = '0;
          r.st = SEQ_FETCH;
        end
      end
      r.cf1 = 1'b1;
      if (isSingle(s.mode1)) begin
        r.sse1 = 1'b0;
      end
    end
    return r;
  endfunction

  // Window decode and read alignment
  assign win = address[10:8];
  assign idx = address[7:2];
  assign fmtSel = (win == WIN_SIGNED) ? FMT_SIGNED : ((win == WIN_LEFT) ? FMT_LEFT : FMT_RIGHT);

  adcrq_fmt adcrq_fmt_i (
    .raw(resRam[idx]),
    .sel(fmtSel),
    .word(fmtWord)
  );

  assign cmdWord = cmdRam[q.command_word_pointer];

  always_comb begin
    qs1 = QS_IDLE;
    qs2 = QS_IDLE;
    if (q.st != SEQ_IDLE) begin
      if (q.act2) begin
        qs2 = (q.st == SEQ_PAUSE) ? QS_PAUSED : QS_ACTIVE;
      end else begin
        qs1 = (q.st == SEQ_PAUSE) ? QS_PAUSED : QS_ACTIVE;
      end
    end
    ctrlRead = '0;
    ctrlRead[CTRL_MODE1 +: MODE_W] = q.mode1;
    ctrlRead[CTRL_SSE1] = q.sse1;
    ctrlRead[CTRL_MODE2 +: MODE_W] = q.mode2;
    ctrlRead[CTRL_SSE2] = q.sse2;
    ctrlRead[CTRL_BQ2 +: BQ2_W] = q.bq2;
    statRead = '0;
    statRead[STAT_CF1] = q.cf1;
    statRead[STAT_PF1] = q.pf1;
    statRead[STAT_FIRST_QUEUE_TRIGGER_OVERRUN_FLAG] = q.first_queue_trigger_overrun_flag;
    statRead[STAT_CF2] = q.cf2;
    statRead[STAT_PF2] = q.pf2;
    statRead[STAT_QS +: 4] = {qs1, qs2};
    ptrRead = '0;
    ptrRead[PTR_CWP +: IDX_W] = q.command_word_pointer;
    ptrRead[PTR_DONE1 +: IDX_W] = q.done1;
    ptrRead[PTR_DONE2 +: IDX_W] = q.done2;
  end

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.abort = 1'b0;
    hwWr = 1'b0;

    // Bus handshake: one wait cycle, then the access completes
    d.ack = (read | write) & ~q.ack;
    swWr = write & q.ack;
    if (read && !q.ack) begin
      d.rdata = '0;
      unique case (win)
        WIN_REGS: begin
          if (address == OFS_CTRL) begin
            d.rdata = ctrlRead;
          end else if (address == OFS_STAT) begin
            d.rdata = statRead;
          end else if (address == OFS_PTR) begin
            d.rdata = ptrRead;
          end
        end
        WIN_CMD: d.rdata = {22'h000000, cmdRam[idx]};
        WIN_RIGHT, WIN_SIGNED, WIN_LEFT: d.rdata = {16'h0000, fmtWord};
        default: d.rdata = '0;
      endcase
    end

    // Software writes to tables, always right-aligned
    cmdWr = swWr && (win == WIN_CMD);
    resWr = swWr && ((win == WIN_RIGHT) || (win == WIN_SIGNED) || (win == WIN_LEFT));
    cmdMerged = mergeBe({22'h000000, cmdRam[idx]}, writedata, byteenable);
    resMerged = mergeBe({22'h000000, resRam[idx]}, writedata, byteenable);
    cmdWData = cmdMerged[RES_W-1:0];
    resWData = resMerged[RES_W-1:0];

    // Control register
    ctrlW = mergeBe(ctrlRead, writedata, byteenable);
    swTrig1 = 1'b0;
    swTrig2 = 1'b0;
    if (swWr && address == OFS_CTRL) begin
      d.mode1 = ctrlW[CTRL_MODE1 +: MODE_W];
      d.sse1 = ctrlW[CTRL_SSE1];
      d.mode2 = ctrlW[CTRL_MODE2 +: MODE_W];
      d.sse2 = ctrlW[CTRL_SSE2];
      d.bq2 = ctrlW[CTRL_BQ2 +: BQ2_W];
      swTrig1 = ctrlW[CTRL_SWTRIG1];
      swTrig2 = ctrlW[CTRL_SWTRIG2];
    end

    // Status flags: write one to clear, hardware sets applied later
    clrMask = mergeBe('0, writedata, byteenable);
    if (swWr && address == OFS_STAT) begin
      d.cf1 = q.cf1 & ~clrMask[STAT_CF1];
      d.pf1 = q.pf1 & ~clrMask[STAT_PF1];
      d.first_queue_trigger_overrun_flag = q.first_queue_trigger_overrun_flag & ~clrMask[STAT_FIRST_QUEUE_TRIGGER_OVERRUN_FLAG];
      d.cf2 = q.cf2 & ~clrMask[STAT_CF2];
      d.pf2 = q.pf2 & ~clrMask[STAT_PF2];
    end

    // Trigger pins pass two flip-flops first
    d.trig1S = {q.trig1S[0], extTrig1};
    d.gateS = {q.gateS[0], extGate};
    d.trig2S = {q.trig2S[0], extTrig2};
    d.trig1Prev = q.trig1S[1];
    d.trig2Prev = q.trig2S[1];
    rise1 = q.trig1S[1] & ~q.trig1Prev;
    rise2 = q.trig2S[1] & ~q.trig2Prev;
    gateOpen = q.gateS[1];
    gated1 = isGated(q.mode1);

    q1Trig = ((d.mode1 == MODE_SW_SINGLE) && d.sse1 && swTrig1)
      || ((d.mode1 == MODE_EDGE_SINGLE) && d.sse1 && rise1)
      || ((d.mode1 == MODE_EDGE_CONT) && rise1);
    q1Go = q1Trig || ((((d.mode1 == MODE_GATE_SINGLE) && d.sse1) || (d.mode1 == MODE_GATE_CONT)) && gateOpen);
    q2Trig = ((d.mode2 == MODE_SW_SINGLE) && d.sse2 && swTrig2)
      || ((d.mode2 == MODE_EDGE_SINGLE) && d.sse2 && rise2)
      || ((d.mode2 == MODE_EDGE_CONT) && rise2);

    // Queue sequencer
    unique case (q.st)
      SEQ_IDLE: begin
        if (q1Go) begin
          d.command_word_pointer = '0;
          d.act2 = 1'b0;
          d.st = SEQ_FETCH;
        end else if ((q2Trig || q.q2Pend) && !q.bq2[BQ2_W-1]) begin
          d.command_word_pointer = q.bq2[IDX_W-1:0];
          d.act2 = 1'b1;
          d.q2Pend = 1'b0;
          d.st = SEQ_FETCH;
        end
      end
      SEQ_FETCH: begin
        if (!q.act2 && gated1 && !gateOpen) begin
          d.st = SEQ_IDLE;
        end else if (cmdWord[CMD_CHAN +: IDX_W] == CHAN_END) begin
          d = finishQ(d, gateOpen);
        end else begin
          d.start = 1'b1;
          d.chan = cmdWord[CMD_CHAN +: IDX_W];
          d.smp = cmdWord[CMD_SMP +: 2];
          d.st = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (!q.act2 && gated1 && !gateOpen) begin
          d.gateStop = 1'b1;
        end
        if (convDone) begin
          hwWr = 1'b1;
          if (q.act2) begin
            d.done2 = q.command_word_pointer;
          end else begin
            d.done1 = q.command_word_pointer;
          end
          if (d.gateStop) begin
            d.gateStop = 1'b0;
            d.st = SEQ_IDLE;
          end else if (cmdWord[CMD_PAUSE]) begin
            d.st = SEQ_PAUSE;
            if (q.act2) begin
              d.pf2 = 1'b1;
            end else begin
              d.pf1 = 1'b1;
            end
          end else if (lastOf(q.command_word_pointer, q.act2, q.bq2)) begin
            d = finishQ(d, gateOpen);
          end else begin
            d.command_word_pointer = q.command_word_pointer + 6'h01;
            d.st = SEQ_FETCH;
          end
        end
      end
      SEQ_PAUSE: begin
        if (!q.act2 && gated1 && !gateOpen) begin
          d.st = SEQ_IDLE;
        end else if (q.act2 ? q2Trig : q1Go) begin
          if (lastOf(q.command_word_pointer, q.act2, q.bq2)) begin
            d = finishQ(d, gateOpen);
          end else begin
            d.command_word_pointer = q.command_word_pointer + 6'h01;
            d.st = SEQ_FETCH;
          end
        end
      end
    endcase

    // First queue preempts the second
    if (q1Go && q.act2 && (q.st != SEQ_IDLE)) begin
      d.abort = (q.st == SEQ_CONV);
      d.start = 1'b0;
      d.q2Pend = 1'b1;
      d.command_word_pointer = '0;
      d.act2 = 1'b0;
      d.gateStop = 1'b0;
      d.st = SEQ_FETCH;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.bq2 <= RST_BQ2;
    end else begin
      q <= d;
    end
  end

  // Tables carry no reset
  always_ff @(posedge ref_clk) begin
    if (hwWr) begin
      resRam[q.command_word_pointer] <= convResult;
    end else if (resWr) begin
      resRam[idx] <= resWData;
    end
    if (cmdWr) begin
      cmdRam[idx] <= cmdWData;
    end
  end

  assign readdata = q.rdata;
  assign waitrequest = ~q.ack;
  assign convStart = q.start;
  assign convChannel = q.chan;
  assign convSample = q.smp;
  assign convAbort = q.abort;
endmodule

// ===== shared/adcrq_pkg.sv
// Constants and types of the converter result table and queue sequencer
package adcrq_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int RES_W = 10;
  localparam int IDX_W = 6;
  localparam int ENTRIES = 64;
  localparam int BQ2_W = 7;
  localparam int MODE_W = 3;

  // Register offsets and table windows
  localparam logic [ADDR_W-1:0] OFS_CTRL = 11'h000;
  localparam logic [ADDR_W-1:0] OFS_STAT = 11'h004;
  localparam logic [ADDR_W-1:0] OFS_PTR = 11'h008;
  localparam logic [2:0] WIN_REGS = 3'h0;
  localparam logic [2:0] WIN_CMD = 3'h1;
  localparam logic [2:0] WIN_RIGHT = 3'h2;
  localparam logic [2:0] WIN_SIGNED = 3'h3;
  localparam logic [2:0] WIN_LEFT = 3'h4;

  // Control register fields
  localparam int CTRL_MODE1 = 0;
  localparam int CTRL_SSE1 = 3;
  localparam int CTRL_MODE2 = 4;
  localparam int CTRL_SSE2 = 7;
  localparam int CTRL_BQ2 = 8;
  localparam int CTRL_SWTRIG1 = 16;
  localparam int CTRL_SWTRIG2 = 17;

  // Status register fields
  localparam int STAT_CF1 = 0;
  localparam int STAT_PF1 = 1;
  localparam int STAT_FIRST_QUEUE_TRIGGER_OVERRUN_FLAG = 2;
  localparam int STAT_CF2 = 3;
  localparam int STAT_PF2 = 4;
  localparam int STAT_QS = 8;

  // Pointer register fields
  localparam int PTR_CWP = 0;
  localparam int PTR_DONE1 = 8;
  localparam int PTR_DONE2 = 16;

  // Command word fields
  localparam int CMD_CHAN = 0;
  localparam int CMD_SMP = 6;
  localparam int CMD_PAUSE = 9;
  localparam logic [IDX_W-1:0] CHAN_END = 6'h3F;

  // Queue operating modes
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SW_SINGLE = 3'h1;
  localparam logic [MODE_W-1:0] MODE_EDGE_SINGLE = 3'h2;
  localparam logic [MODE_W-1:0] MODE_GATE_SINGLE = 3'h3;
  localparam logic [MODE_W-1:0] MODE_GATE_CONT = 3'h4;
  localparam logic [MODE_W-1:0] MODE_EDGE_CONT = 3'h5;

  // Reset values
  localparam logic [BQ2_W-1:0] RST_BQ2 = 7'h40;

  // Queue status codes per queue
  localparam logic [1:0] QS_IDLE = 2'h0;
  localparam logic [1:0] QS_PAUSED = 2'h1;
  localparam logic [1:0] QS_ACTIVE = 2'h2;

  // Read alignment selects
  localparam logic [1:0] FMT_RIGHT = 2'h0;
  localparam logic [1:0] FMT_SIGNED = 2'h1;
  localparam logic [1:0] FMT_LEFT = 2'h2;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FETCH, SEQ_CONV, SEQ_PAUSE} adcrq_seq_t;
endpackage

// ===== sim/adc_result_table_queue_seq_tb.sv
// Self-checking bench for the result table and queue sequencer
`timescale 1ns/1ps
module adc_result_table_queue_seq_tb;
  import adcrq_pkg::*;
  logic ref_clk, rst_b, read, write, extTrig1, extGate, extTrig2, slow;
  logic waitrequest, convStart, convAbort, convDone;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata, q;
  logic [BE_W-1:0] byteenable;
  logic [IDX_W-1:0] convChannel, lastCh;
  logic [1:0] convSample, lastSmp;
  logic [RES_W-1:0] convResult;
  int bad_count, check_count, starts, aborts;
  adcrq_top #(.DEPTH(64)) adcrq_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .extTrig1(extTrig1), .extGate(extGate), .extTrig2(extTrig2),
    .convStart(convStart), .convChannel(convChannel), .convSample(convSample), .convAbort(convAbort),
    .convDone(convDone), .convResult(convResult));
  adcrq_conv_model adcrq_conv_model_i (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow), .convStart(convStart),
    .convChannel(convChannel), .convAbort(convAbort), .convDone(convDone), .convResult(convResult));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (convStart === 1'b1) begin
      starts <= starts + 1;
      lastCh <= convChannel;
      lastSmp <= convSample;
    end
    if (convAbort === 1'b1) begin
      aborts <= aborts + 1;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  function automatic logic [ADDR_W-1:0] ad(input logic [2:0] w, input int i);
    return {w, 6'(i), 2'b00};
  endfunction
  function automatic logic [9:0] res(input logic [5:0] c);
    return {~c[3:0], c};
  endfunction
  function automatic logic [31:0] fmtv(input logic [9:0] r, input int w);
    case (w)
      0: return {22'h0, r};
      1: return {16'h0, ~r[9], r[8:0], 6'h00};
      default: return {16'h0, r, 6'h00};
    endcase
  endfunction
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      bus(1'b0, OFS_STAT, 32'h0);
      k++;
    end while ((q & m) !== v && k < 200);
    if ((q & m) !== v) begin
      bad_count++;
    end
  endtask
  task automatic wait_starts(input int n);
    int k;
    k = 0;
    while (starts < n && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    if (starts < n) begin
      bad_count++;
    end
  endtask
  task automatic pulse(input bit two);
    @(posedge ref_clk);
    if (two)
      extTrig2 <= 1'b1;
    else
      extTrig1 <= 1'b1;
    repeat (4) @(posedge ref_clk);
    extTrig1 <= 1'b0;
    extTrig2 <= 1'b0;
  endtask
  task automatic t_table;
    bus(1'b0, OFS_STAT, 32'h0);
    check("queue status", q[11:8], 0);
    bus(1'b0, 11'h7FC, 32'h0);
    check("unmapped read", q, 0);
    for (int w = 0; w < 3; w++)
      bus(1'b1, ad(3'(WIN_RIGHT + w), 63 - w), 32'hFFFF_FD5A ^ 32'(w * 37));
    for (int e = 0; e < 3; e++)
      for (int w = 0; w < 3; w++) begin
        bus(1'b0, ad(3'(WIN_RIGHT + w), 63 - e), 32'h0);
        check("result word", q, fmtv(10'(32'h15A ^ 32'(e * 37)), w));
      end
    $display("table test done");
  endtask
  task automatic t_pause;
    bus(1'b1, ad(WIN_CMD, 0), 32'h205);
    bus(1'b1, ad(WIN_CMD, 1), 32'h006);
    bus(1'b1, ad(WIN_CMD, 2), 32'h0C7);
    bus(1'b1, ad(WIN_CMD, 3), 32'h03F);
    slow <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h400A);
    pulse(1'b0);
    wait_starts(1);
    bus(1'b0, OFS_STAT, 32'h0);
    check("active status", q[11:8], 8);
    slow <= 1'b0;
    poll(32'hF02, 32'h402);
    check("paused status", q[11:8], 4);
    bus(1'b0, OFS_PTR, 32'h0);
    check("pointer at pause", q[13:0], 0);
    check("starts at pause", starts, 1);
    bus(1'b0, ad(WIN_RIGHT, 0), 32'h0);
    check("first result", q, res(5));
    pulse(1'b0);
    poll(32'hF01, 32'h001);
    check("starts at end", starts, 3);
    check("sample code", lastSmp, 3);
    bus(1'b0, OFS_PTR, 32'h0);
    check("first last done", q[13:8], 2);
    bus(1'b0, ad(WIN_RIGHT, 2), 32'h0);
    check("third result", q, res(7));
    bus(1'b0, OFS_CTRL, 32'h0);
    check("single scan enable", q[3], 0);
    $display("pause test done");
  endtask
  task automatic t_gate;
    int s;
    s = starts;
    bus(1'b1, 11'h004, 32'h1F);
    bus(1'b1, ad(WIN_CMD, 0), 32'h008);
    bus(1'b1, OFS_CTRL, 32'h400B);
    extGate <= 1'b1;
    wait_starts(s + 1);
    slow <= 1'b1;
    wait_starts(s + 2);
    extGate <= 1'b0;
    poll(32'hF00, 32'h0);
    check("starts after close", starts, s + 2);
    bus(1'b0, ad(WIN_RIGHT, 1), 32'h0);
    check("finished result", q, res(6));
    extGate <= 1'b1;
    wait_starts(s + 3);
    check("restart channel", lastCh, 8);
    extGate <= 1'b0;
    slow <= 1'b0;
    poll(32'hF00, 32'h0);
    bus(1'b1, OFS_STAT, 32'h1F);
    bus(1'b1, OFS_CTRL, 32'h4004);
    extGate <= 1'b1;
    poll(32'h4, 32'h4);
    check("complete and overrun", {q[2], q[0]}, 2'b11);
    extGate <= 1'b0;
    poll(32'hF00, 32'h0);
    $display("gate test done");
  endtask
  task automatic t_preempt;
    int s;
    s = starts;
    bus(1'b1, OFS_STAT, 32'h1F);
    bus(1'b1, ad(WIN_CMD, 4), 32'h009);
    bus(1'b1, ad(WIN_CMD, 5), 32'h03F);
    slow <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h04D9);
    pulse(1'b1);
    wait_starts(s + 1);
    check("second queue channel", lastCh, 9);
    bus(1'b1, OFS_CTRL, 32'h104D9);
    wait_starts(s + 2);
    check("first queue channel", lastCh, 8);
    check("aborts", aborts, 1);
    slow <= 1'b0;
    poll(32'h9, 32'h9);
    bus(1'b0, ad(WIN_RIGHT, 4), 32'h0);
    check("second queue result", q, res(9));
    $display("preempt test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    finish_test;
  end
  initial begin
    {rst_b, read, write, extTrig1, extGate, extTrig2, slow} = 7'h00;
    address = 11'h000;
    writedata = 32'h0;
    byteenable = 4'hF;
    {bad_count, check_count} = 64'h0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_table;
    t_pause;
    t_gate;
    t_preempt;
    finish_test;
  end
endmodule

// ===== sim/adcrq_conv_model.sv
// Converter model answering start pulses with a result after a delay
`timescale 1ns/1ps
module adcrq_conv_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic convStart,
  input wire logic [adcrq_pkg::IDX_W-1:0] convChannel,
  input wire logic convAbort,
  output logic convDone,
  output logic [adcrq_pkg::RES_W-1:0] convResult
);
  logic [5:0] cnt_q;
  logic [5:0] ch_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 6'h00;
      ch_q <= 6'h00;
      convDone <= 1'b0;
      convResult <= 10'h000;
    end else begin
      convDone <= 1'b0;
      convResult <= ~convResult;
      if (convStart) begin
        cnt_q <= slow ? 6'h28 : 6'h02;
        ch_q <= convChannel;
      end else if (convAbort) begin
        cnt_q <= 6'h00;
      end else if (cnt_q == 6'h01) begin
        cnt_q <= 6'h00;
        convDone <= 1'b1;
        convResult <= {~ch_q[3:0], ch_q};
      end else if (cnt_q != 6'h00) begin
        cnt_q <= cnt_q - 6'h01;
      end
    end
  end
endmodule

// ===== sim/adcrq_monitor.sv
// Concurrent checks on the result table and queue sequencer ports
`timescale 1ns/1ps
module adcrq_monitor #(
  parameter int DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [adcrq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [adcrq_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic convStart,
  input wire logic [adcrq_pkg::IDX_W-1:0] convChannel,
  input wire logic convAbort,
  input wire logic convDone
);
  import adcrq_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic rdEnd;
  assign rdEnd = read && !waitrequest;
  property p_ack_one; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ack_one: assert property (p_ack_one) else $error("request not answered after one wait cycle");
  property p_ack_short; !waitrequest |=> waitrequest; endproperty
  a_ack_short: assert property (p_ack_short) else $error("waitrequest low for more than one cycle");
  property p_no_req; !(read || write) |=> waitrequest; endproperty
  a_no_req: assert property (p_no_req) else $error("answer without a request");
  property p_right; rdEnd && address[10:8] == WIN_RIGHT |-> readdata[31:10] == 22'h0; endproperty
  a_right: assert property (p_right) else $error("right format upper bits not zero");
  property p_signed; rdEnd && address[10:8] == WIN_SIGNED |-> readdata[5:0] == 6'h0 && readdata[31:16] == 16'h0;
  endproperty
  a_signed: assert property (p_signed) else $error("signed format unused bits not zero");
  property p_left; rdEnd && address[10:8] == WIN_LEFT |-> readdata[5:0] == 6'h0 && readdata[31:16] == 16'h0;
  endproperty
  a_left: assert property (p_left) else $error("left format unused bits not zero");
  property p_start; convStart |=> !convStart; endproperty
  a_start: assert property (p_start) else $error("start pulse longer than one cycle");
  property p_abort; convAbort |=> !convAbort; endproperty
  a_abort: assert property (p_abort) else $error("abort pulse longer than one cycle");
  property p_gap; convDone |=> !convStart; endproperty
  a_gap: assert property (p_gap) else $error("start right after end of conversion");
  property p_chan; $changed(convChannel) |-> convStart; endproperty
  a_chan: assert property (p_chan) else $error("channel changed without a start");
  c_read: cover property (rdEnd);
  c_conv: cover property (convStart ##[1:100] convDone);
  c_abort: cover property (convAbort);
endmodule
bind adcrq_top adcrq_monitor #(.DEPTH(DEPTH)) adcrq_monitor_i (.ref_clk(ref_clk), .rst_b(rst_b),
  .address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .convStart(convStart), .convChannel(convChannel), .convAbort(convAbort), .convDone(convDone));
